// *** rtl/cod_gain_step.sv ***
// Output gain stepper that walks the applied gain toward the programmed gain.
`timescale 1ns/1ps
`default_nettype none
`include "cod_map.svh"
module cod_gain_step
  import cod_pkg::*;
(
  // Clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RST,
  // Stepping control
  cod_step_if.stepper st
);

  cod_gain_t applied_reg;
  cod_gain_t applied_next;
  logic      phase_reg;
  logic      phase_next;
  logic      step_due;

  // ==========================================================================
  // Stepping
  // gain walk
  always_comb begin
    phase_next   = phase_reg;
    applied_next = applied_reg;
    step_due     = 1'b0;
    if (st.fs_tick) begin
      phase_next = ~phase_reg;
      case (st.rate)
        COD_STEP_EVERY_FS:  step_due = 1'b1;
        COD_STEP_EVERY_2FS: step_due = phase_reg;
        default:            step_due = 1'b0;
      endcase
    end
    // The reserved rate code is treated as disabled so the gain never stalls.
    if ((st.rate == COD_STEP_OFF) || (st.rate == COD_STEP_RSVD)) begin
      applied_next = st.target;
      phase_next   = 1'b0;
    end else if (step_due && (applied_reg != st.target)) begin
      if (applied_reg < st.target) begin
        applied_next = applied_reg + 7'h01;
      end else begin
        applied_next = applied_reg - 7'h01;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      applied_reg <= `COD_GAIN_RST;
      phase_reg   <= 1'b0;
    end else begin
      applied_reg <= applied_next;
      phase_reg   <= phase_next;
    end
  end

  assign st.applied = applied_reg;
  assign st.settled = (applied_reg == st.target);

endmodule
`default_nettype wire

// *** rtl/cod_map.svh ***
// Register offsets, field positions, reset values and gain and driver constants of the output driver control bank.
`ifndef COD_MAP_SVH
`define COD_MAP_SVH

// ==========================================================================
// Register offsets
`define COD_OFS_DAC_PWR    8'h25
`define COD_OFS_HP_CTRL    8'h26
`define COD_OFS_RSVD_27    8'h27
`define COD_OFS_OUT_STAGE  8'h28

// ==========================================================================
// Field positions
`define COD_DAC_PWR_LEFT_BIT    7
`define COD_DAC_PWR_RIGHT_BIT   6
`define COD_LCOM_HI             5
`define COD_LCOM_LO             4
`define COD_RCOM_HI             5
`define COD_RCOM_LO             3
`define COD_PROT_EN_BIT         2
`define COD_PROT_MODE_BIT       1
`define COD_VCM_HI              7
`define COD_VCM_LO              6
`define COD_L2L_HI              5
`define COD_L2L_LO              4
`define COD_L2R_HI              3
`define COD_L2R_LO              2
`define COD_STEP_HI             1
`define COD_STEP_LO             0

// ==========================================================================
// Writable masks and reset values
`define COD_DAC_PWR_WMASK   8'hF0
`define COD_HP_CTRL_WMASK   8'h3E
`define COD_OUT_STAGE_WMASK 8'hFF
`define COD_DAC_PWR_RST     8'h00
`define COD_HP_CTRL_RST     8'h00
`define COD_RSVD_27_VAL     8'h00
`define COD_OUT_STAGE_RST   8'h00

// ==========================================================================
// Gain and driver count
`define COD_GAIN_W          7
`define COD_GAIN_RST        7'h00
`define COD_NUM_DRV         4

`endif

// *** rtl/cod_out_drv_regs.sv ***
// Output driver control register bank with short protection and output gain soft-stepping.
`timescale 1ns/1ps
`default_nettype none
`include "cod_map.svh"
module cod_out_drv_regs
  import cod_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Register port from the control bus front end
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // Power and driver configuration
  output logic            LEFT_DAC_PWR,
  output logic            RIGHT_DAC_PWR,
  output logic      [1:0] LEFT_COMPLEMENTARY_HP_DRIVER_MODE,
  output logic      [2:0] RIGHT_COMPLEMENTARY_HP_DRIVER_MODE,
  output logic      [1:0] COMMON_MODE_LEVEL,
  output logic      [1:0] LEFT_LINE_TWO_INPUT_BYPASS,
  output logic      [1:0] RIGHT_LINE_TWO_INPUT_BYPASS,
  // Short protection, one bit per high-power driver
  input  wire logic [3:0] SHORT_DETECT,
  output logic      [3:0] DRV_CURRENT_LIMIT,
  output logic      [3:0] DRV_POWER_DOWN,
  // Output gain soft-stepping
  input  wire logic       FS_TICK,
  input  wire logic [6:0] TARGET_GAIN,
  output logic      [6:0] APPLIED_GAIN,
  output logic            GAIN_SETTLED
);

  logic [7:0] dac_pwr_reg;
  logic [7:0] dac_pwr_next;
  logic [7:0] hp_ctrl_reg;
  logic [7:0] hp_ctrl_next;
  logic [7:0] out_stage_reg;
  logic [7:0] out_stage_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] short_meta_reg;
  logic [3:0] short_sync_reg;
  logic [3:0] limit_reg;
  logic [3:0] limit_next;
  logic [3:0] pdown_reg;
  logic [3:0] pdown_next;
  logic       prot_en;
  logic       prot_mode;

  cod_step_if step_bus ();

  // ==========================================================================
  // Register writes
  always_comb begin
    dac_pwr_next   = dac_pwr_reg;
    hp_ctrl_next   = hp_ctrl_reg;
    out_stage_next = out_stage_reg;
    if (REG_WR) begin
      case (REG_ADDR)
        // power write, low bits held zero
        `COD_OFS_DAC_PWR:   dac_pwr_next = REG_WDATA & `COD_DAC_PWR_WMASK;
        // driver control write, reserved bits held zero
        `COD_OFS_HP_CTRL:   hp_ctrl_next = REG_WDATA & `COD_HP_CTRL_WMASK;
        `COD_OFS_OUT_STAGE: out_stage_next = REG_WDATA & `COD_OUT_STAGE_WMASK;
        default:            dac_pwr_next = dac_pwr_reg;
      endcase
    end
  end

  // ==========================================================================
  // Register reads
  always_comb begin
    rdata_next = rdata_reg;
    if (REG_RD) begin
      case (REG_ADDR)
        `COD_OFS_DAC_PWR:   rdata_next = dac_pwr_reg;
        `COD_OFS_HP_CTRL:   rdata_next = hp_ctrl_reg;
        `COD_OFS_RSVD_27:   rdata_next = `COD_RSVD_27_VAL;
        `COD_OFS_OUT_STAGE: rdata_next = out_stage_reg;
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dac_pwr_reg   <= `COD_DAC_PWR_RST;
      hp_ctrl_reg   <= `COD_HP_CTRL_RST;
      out_stage_reg <= `COD_OUT_STAGE_RST;
      rdata_reg     <= 8'h00;
    end else begin
      dac_pwr_reg   <= dac_pwr_next;
      hp_ctrl_reg   <= hp_ctrl_next;
      out_stage_reg <= out_stage_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ==========================================================================
  // Short protection
  // Detectors are analog comparators, so they pass two flip-flops first.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      short_meta_reg <= 4'h0;
      short_sync_reg <= 4'h0;
    end else begin
      short_meta_reg <= SHORT_DETECT;
      short_sync_reg <= short_meta_reg;
    end
  end

  assign prot_en   = hp_ctrl_reg[`COD_PROT_EN_BIT];
  assign prot_mode = hp_ctrl_reg[`COD_PROT_MODE_BIT];

  always_comb begin
    // limit follows the short while enabled in limit mode
    limit_next = (prot_en && !prot_mode) ? short_sync_reg : 4'h0;
    // shutdown latches until protection or its mode is cleared
    if (prot_en && prot_mode) begin
      pdown_next = pdown_reg | short_sync_reg;
    end else begin
      pdown_next = 4'h0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      limit_reg <= 4'h0;
      pdown_reg <= 4'h0;
    end else begin
      limit_reg <= limit_next;
      pdown_reg <= pdown_next;
    end
  end

  // ==========================================================================
  // Gain stepper
  assign step_bus.fs_tick = FS_TICK;
  assign step_bus.rate    = cod_step_rate_e'(out_stage_reg[`COD_STEP_HI:`COD_STEP_LO]);
  assign step_bus.target  = TARGET_GAIN;

  cod_gain_step u_step (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .st       (step_bus.stepper)
  );

  // ==========================================================================
  // Outputs
  assign REG_RDATA                          = rdata_reg;
  assign LEFT_DAC_PWR                       = dac_pwr_reg[`COD_DAC_PWR_LEFT_BIT];
  assign RIGHT_DAC_PWR                      = dac_pwr_reg[`COD_DAC_PWR_RIGHT_BIT];
  assign LEFT_COMPLEMENTARY_HP_DRIVER_MODE  = dac_pwr_reg[`COD_LCOM_HI:`COD_LCOM_LO];
  assign RIGHT_COMPLEMENTARY_HP_DRIVER_MODE = hp_ctrl_reg[`COD_RCOM_HI:`COD_RCOM_LO];
  assign COMMON_MODE_LEVEL                  = out_stage_reg[`COD_VCM_HI:`COD_VCM_LO];
  assign LEFT_LINE_TWO_INPUT_BYPASS         = out_stage_reg[`COD_L2L_HI:`COD_L2L_LO];
  assign RIGHT_LINE_TWO_INPUT_BYPASS        = out_stage_reg[`COD_L2R_HI:`COD_L2R_LO];
  assign DRV_CURRENT_LIMIT                  = limit_reg;
  assign DRV_POWER_DOWN                     = pdown_reg;
  assign APPLIED_GAIN                       = step_bus.applied;
  assign GAIN_SETTLED                       = step_bus.settled;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Register effects are checked one cycle after the strobe, once the flip-flops have taken the write.
  a_left_dac_write: assert property (REG_WR && REG_ADDR == `COD_OFS_DAC_PWR
      |=> LEFT_DAC_PWR == $past(REG_WDATA[7]))
    else $error("Left DAC power does not follow write.");
  a_right_dac_write: assert property (REG_WR && REG_ADDR == `COD_OFS_DAC_PWR
      |=> RIGHT_DAC_PWR == $past(REG_WDATA[6]))
    else $error("Right DAC power does not follow write.");
  a_left_com_mode: assert property (REG_WR && REG_ADDR == `COD_OFS_DAC_PWR
      |=> LEFT_COMPLEMENTARY_HP_DRIVER_MODE == $past(REG_WDATA[5:4]))
    else $error("Left complementary mode does not follow write.");
  a_pwr_low_zero: assert property (REG_RD && REG_ADDR == `COD_OFS_DAC_PWR
      |=> REG_RDATA[3:0] == 4'h0)
    else $error("Reserved power bits read nonzero.");
  a_right_com_mode: assert property (REG_WR && REG_ADDR == `COD_OFS_HP_CTRL
      |=> RIGHT_COMPLEMENTARY_HP_DRIVER_MODE == $past(REG_WDATA[5:3]))
    else $error("Right complementary mode does not follow write.");
  a_limit_mode: assert property (prot_en && !prot_mode && short_sync_reg[0]
      |=> DRV_CURRENT_LIMIT[0] && !DRV_POWER_DOWN[0])
    else $error("Limit mode did not limit driver zero.");
  a_limit_follow: assert property (prot_en && !prot_mode
      |=> DRV_CURRENT_LIMIT == $past(short_sync_reg))
    else $error("Current limit does not follow the detectors.");
  a_pdown_mode: assert property (prot_en && prot_mode && short_sync_reg[0]
      ##1 prot_en && prot_mode |-> DRV_POWER_DOWN[0] [*2])
    else $error("Shutdown mode did not hold driver zero down.");
  a_pdown_clear: assert property (!(prot_en && prot_mode)
      |=> DRV_POWER_DOWN == 4'h0)
    else $error("Shutdown held while its mode was off.");
  a_prot_off_quiet: assert property (!prot_en
      |=> DRV_CURRENT_LIMIT == 4'h0 && DRV_POWER_DOWN == 4'h0)
    else $error("Protection acted while disabled.");
  a_hp_rsvd_zero: assert property (REG_RD && REG_ADDR == `COD_OFS_HP_CTRL
      |=> REG_RDATA[7:6] == 2'h0 && !REG_RDATA[0])
    else $error("Reserved driver control bits read nonzero.");
  a_rsvd_reg_zero: assert property (REG_RD && REG_ADDR == `COD_OFS_RSVD_27
      |=> REG_RDATA == 8'h00)
    else $error("Reserved register read nonzero.");
  a_stray_write_ignored: assert property (REG_WR && (REG_ADDR == `COD_OFS_RSVD_27
      || REG_ADDR < `COD_OFS_DAC_PWR || REG_ADDR > `COD_OFS_OUT_STAGE)
      |=> $stable(dac_pwr_reg) && $stable(hp_ctrl_reg) && $stable(out_stage_reg))
    else $error("A stray write changed a register.");
  a_vcm_write: assert property (REG_WR && REG_ADDR == `COD_OFS_OUT_STAGE
      |=> COMMON_MODE_LEVEL == $past(REG_WDATA[7:6]))
    else $error("Common-mode level does not follow write.");
  a_bypass_write: assert property (REG_WR && REG_ADDR == `COD_OFS_OUT_STAGE
      |=> LEFT_LINE_TWO_INPUT_BYPASS == $past(REG_WDATA[5:4]) && RIGHT_LINE_TWO_INPUT_BYPASS == $past(REG_WDATA[3:2]))
    else $error("Bypass selects do not follow write.");
  a_right_bypass: assert property (REG_WR && REG_ADDR == `COD_OFS_OUT_STAGE
      |=> RIGHT_LINE_TWO_INPUT_BYPASS == $past(REG_WDATA[3:2]))
    else $error("Right bypass select does not follow write.");
  a_step_off_direct: assert property (out_stage_reg[1:0] == 2'h2 && $stable(out_stage_reg)
      |=> APPLIED_GAIN == $past(TARGET_GAIN))
    else $error("Disabled stepping did not apply gain at once.");
  a_step_one_lsb: assert property (out_stage_reg[1:0] == 2'h0 && $stable(out_stage_reg)
      |=> (APPLIED_GAIN == $past(APPLIED_GAIN)) || (APPLIED_GAIN == $past(APPLIED_GAIN) + 7'h01)
       || (APPLIED_GAIN == $past(APPLIED_GAIN) - 7'h01))
    else $error("Gain moved by more than one step.");
  a_step_hold: assert property (out_stage_reg[1] == 1'b0 && !FS_TICK
      |=> $stable(APPLIED_GAIN))
    else $error("Gain moved without a sample tick.");

  // Covers mark the main scenarios: a latched shutdown, a limited short, a gain walk and a reserved read.
  c_pdown_seen: cover property (DRV_POWER_DOWN != 4'h0);
  c_rate_two_fs: cover property (out_stage_reg[1:0] == 2'h1 && FS_TICK && !GAIN_SETTLED);
  c_limit_seen: cover property (DRV_CURRENT_LIMIT != 4'h0);
  c_gain_walk: cover property (!GAIN_SETTLED ##1 !GAIN_SETTLED ##1 GAIN_SETTLED);
  c_rsvd_read: cover property (REG_RD && REG_ADDR == `COD_OFS_RSVD_27);

endmodule
`default_nettype wire

// *** rtl/cod_pkg.sv ***
// Types shared by the output driver control bank and its gain stepper.
package cod_pkg;

  typedef enum logic [1:0] {
    COD_STEP_EVERY_FS   = 2'h0,
    COD_STEP_EVERY_2FS  = 2'h1,
    COD_STEP_OFF        = 2'h2,
    COD_STEP_RSVD       = 2'h3
  } cod_step_rate_e;

  typedef enum logic [1:0] {
    COD_LCOM_DIFF   = 2'h0,
    COD_LCOM_VCM    = 2'h1,
    COD_LCOM_SE     = 2'h2,
    COD_LCOM_RSVD   = 2'h3
  } cod_lcom_mode_e;

  typedef enum logic [2:0] {
    COD_RCOM_DIFF_MAIN = 3'h0,
    COD_RCOM_VCM       = 3'h1,
    COD_RCOM_SE        = 3'h2,
    COD_RCOM_DIFF_LCOM = 3'h3,
    COD_RCOM_EXT_FB    = 3'h4
  } cod_rcom_mode_e;

  typedef logic [6:0] cod_gain_t;

endpackage

// *** rtl/cod_step_if.sv ***
// Carrier between the register bank and the output gain stepper.
`timescale 1ns/1ps
`default_nettype none
interface cod_step_if;
  import cod_pkg::*;
  logic           fs_tick;
  cod_step_rate_e rate;
  cod_gain_t      target;
  cod_gain_t      applied;
  logic           settled;

  modport bank (output fs_tick, output rate, output target, input applied, input settled);
  modport stepper (input fs_tick, input rate, input target, output applied, output settled);
endinterface
`default_nettype wire

// *** tb/cod_out_drv_regs_tb.sv ***
// Self-checking bench of the output driver control bank against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
`include "cod_map.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module cod_out_drv_regs_tb;
  import cod_pkg::*;
  logic       CORE_CLK = 1'b0;
  logic       RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic       REG_WR = 1'b0;
  logic       REG_RD = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA;
  logic       LEFT_DAC_PWR, RIGHT_DAC_PWR;
  logic [1:0] lcom, common_mode_level, l2l, l2r;
  logic [2:0] rcom;
  logic [3:0] SHORT_DETECT = 4'h0;
  logic [3:0] DRV_CURRENT_LIMIT, DRV_POWER_DOWN;
  logic       FS_TICK = 1'b0;
  logic [6:0] TARGET_GAIN = 7'h00;
  logic [6:0] APPLIED_GAIN;
  logic       GAIN_SETTLED;
  int         fail_count = 0;
  int         samples_checked = 0;
  integer     seed = 32'hA1E4B4B7;
  logic [7:0] mdl [0:3] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wmask [0:3] = '{`COD_DAC_PWR_WMASK, `COD_HP_CTRL_WMASK, 8'h00, `COD_OUT_STAGE_WMASK};
  logic [6:0] m_app = 7'h00;
  logic       m_ph = 1'b0;
  logic [3:0] pat;
  logic [7:0] d;

  always #25 CORE_CLK = ~CORE_CLK;

  cod_out_drv_regs i_cod_out_drv_regs (
    .CORE_CLK                           (CORE_CLK),
    .RST                                (RST),
    .REG_ADDR                           (REG_ADDR),
    .REG_WR                             (REG_WR),
    .REG_RD                             (REG_RD),
    .REG_WDATA                          (REG_WDATA),
    .REG_RDATA                          (REG_RDATA),
    .LEFT_DAC_PWR                       (LEFT_DAC_PWR),
    .RIGHT_DAC_PWR                      (RIGHT_DAC_PWR),
    .LEFT_COMPLEMENTARY_HP_DRIVER_MODE  (lcom),
    .RIGHT_COMPLEMENTARY_HP_DRIVER_MODE (rcom),
    .COMMON_MODE_LEVEL                  (common_mode_level),
    .LEFT_LINE_TWO_INPUT_BYPASS         (l2l),
    .RIGHT_LINE_TWO_INPUT_BYPASS        (l2r),
    .SHORT_DETECT                       (SHORT_DETECT),
    .DRV_CURRENT_LIMIT                  (DRV_CURRENT_LIMIT),
    .DRV_POWER_DOWN                     (DRV_POWER_DOWN),
    .FS_TICK                            (FS_TICK),
    .TARGET_GAIN                        (TARGET_GAIN),
    .APPLIED_GAIN                       (APPLIED_GAIN),
    .GAIN_SETTLED                       (GAIN_SETTLED)
  );

  // ==========================================================================
  // Model and bus tasks
  // The gain model steps at every rising edge; the register model changes only at falling edges, so they never race.
  task automatic step(input logic tick);
    if (mdl[3][1]) begin
      m_app = TARGET_GAIN;
      m_ph = 1'b0;
    end else if (tick) begin
      if (!mdl[3][0] || m_ph)
        m_app = m_app + ((TARGET_GAIN > m_app) ? 7'h01 : (TARGET_GAIN < m_app) ? 7'h7F : 7'h00);
      m_ph = ~m_ph;
    end
  endtask

  always @(posedge CORE_CLK) begin
    if (!RST)
      step(FS_TICK);
  end

  task automatic chk_out();
    `CHK("left_dac", mdl[0][7], LEFT_DAC_PWR)
    `CHK("right_dac", mdl[0][6], RIGHT_DAC_PWR)
    `CHK("lcom", mdl[0][5:4], lcom)
    `CHK("rcom", mdl[1][5:3], rcom)
    `CHK("vcm", mdl[3][7:6], common_mode_level)
    `CHK("l2l", mdl[3][5:4], l2l)
    `CHK("l2r", mdl[3][3:2], l2r)
  endtask

  // One idle cycle follows every access so no strobe is assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge CORE_CLK);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    REG_WR = 1'b0;
    if (a >= `COD_OFS_DAC_PWR && a <= `COD_OFS_OUT_STAGE)
      mdl[a - 8'h25] = v & wmask[a - 8'h25];
    chk_out();
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] ex;
    ex = (a >= `COD_OFS_DAC_PWR && a <= `COD_OFS_OUT_STAGE) ? mdl[a - 8'h25] : 8'h00;
    @(negedge CORE_CLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    REG_RD = 1'b0;
    `CHK("rdata", ex, REG_RDATA)
  endtask

  task automatic prot(input logic [7:0] cfg, input logic [3:0] det);
    wr(`COD_OFS_HP_CTRL, cfg);
    SHORT_DETECT = det;
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask

  task automatic gain_run(input logic [1:0] rate);
    wr(`COD_OFS_OUT_STAGE, {6'h00, rate});
    for (int n = 0; n < 120; n++) begin
      @(negedge CORE_CLK);
      `CHK("applied", m_app, APPLIED_GAIN)
      `CHK("settled", (m_app == TARGET_GAIN), GAIN_SETTLED)
      FS_TICK = ($random(seed) & 3) != 0;
      if (n % 40 == 0)
        TARGET_GAIN = 7'($random(seed));
      @(posedge CORE_CLK);
    end
    @(negedge CORE_CLK);
    FS_TICK = 1'b0;
  endtask

  task automatic results();
    $display("Checked %0d values, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST = 1'b0;
    chk_out();
    for (int a = 8'h25; a <= 8'h28; a++)
      rd(8'(a));
    // Every documented code of the mode, level and bypass fields is written at least once, reserved codes and bits left alone.
    for (int i = 0; i < 20; i++) begin
      d = 8'($random(seed));
      case (i % 4)
        0: d = {d[7:6], 2'(i / 4 % 3), 4'h0};
        1: d = {2'h0, 3'(i / 4), d[2:1], 1'b0};
        3: d = {2'(i / 4), 2'(i / 4 + 1), 2'(i / 4 + 2), 1'b0, d[0]};
        default: ;
      endcase
      wr((i % 4 == 2) ? 8'h30 : 8'(8'h25 + i % 4), d);
      rd(8'(8'h25 + i % 4));
      rd(8'h30);
    end
    pat = 4'($random(seed)) | 4'h1;
    prot(8'h04, pat);
    `CHK("limit", pat, DRV_CURRENT_LIMIT)
    `CHK("pdown", 4'h0, DRV_POWER_DOWN)
    // Shorts are cleared first, since shutdown mode would latch any that are still present.
    prot(8'h04, 4'h0);
    `CHK("limit", 4'h0, DRV_CURRENT_LIMIT)
    prot(8'h06, ~pat);
    `CHK("limit", 4'h0, DRV_CURRENT_LIMIT)
    `CHK("pdown", ~pat, DRV_POWER_DOWN)
    prot(8'h06, 4'h0);
    `CHK("pdown", ~pat, DRV_POWER_DOWN)
    prot(8'h02, 4'hF);
    `CHK("limit", 4'h0, DRV_CURRENT_LIMIT)
    `CHK("pdown", 4'h0, DRV_POWER_DOWN)
    SHORT_DETECT = 4'h0;
    gain_run(2'h2);
    gain_run(2'h0);
    gain_run(2'h2);
    gain_run(2'h1);
    gain_run(2'h3);
    results();
  end

  // A hang ends the run well after the main sequence should have finished.
  initial begin
    #(50 * 20000);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
